// file: include/pin_mux_pkg.sv
/*
 pin_mux_pkg: register offsets, field positions, reset values and the
 carrier structs for the pin-location multiplexer.
 assumes a 25 MHz single clock system; nothing here is clocked.
*/
package pin_mux_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [1:0] IDX_LUT_EVENT = 2'h0;
  localparam logic [1:0] IDX_COMM_PINS = 2'h1;
  localparam logic [1:0] IDX_TIMER_A = 2'h2;
  localparam logic [1:0] IDX_TIMER_B = 2'h3;

  localparam int POS_TABLE_ONE = 5;
  localparam int POS_TABLE_ZERO = 4;
  localparam int POS_EVENT_TWO = 2;
  localparam int POS_EVENT_ONE = 1;
  localparam int POS_EVENT_ZERO = 0;
  localparam int POS_TWO_WIRE = 4;
  localparam int POS_SERIAL_PERIPH = 2;
  localparam int POS_ASYNC_SERIAL = 0;
  localparam int POS_WAVE_HIGH_LSB = 3;
  localparam int POS_WAVE_LOW_LSB = 0;
  localparam int POS_TIMER_B_ONE = 1;
  localparam int POS_TIMER_B_ZERO = 0;

  // writable bits of each register; all other bits read zero
  localparam logic [7:0] MASK_LUT_EVENT = 8'h37;
  localparam logic [7:0] MASK_COMM_PINS = 8'h15;
  localparam logic [7:0] MASK_TIMER_A = 8'h3F;
  localparam logic [7:0] MASK_TIMER_B = 8'h03;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } bus_req_s;

  typedef struct packed {
    logic table_one_alt_pin;
    logic table_zero_alt_pin;
    logic event_pin_two_enable;
    logic event_pin_one_enable;
    logic event_pin_zero_enable;
    logic two_wire_alt_pins;
    logic serial_periph_alt_pins;
    logic async_serial_alt_pins;
    logic [5:0] timer_a_wave_alt_pin;
    logic timer_b_one_alt_pin;
    logic timer_b_zero_alt_pin;
  } pin_select_s;
endpackage

// file: logic/ctrl_reg8.sv
/*
 ctrl_reg8: one 8-bit control register with a write mask.
 assumes a single synchronous reset and one write strobe per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module ctrl_reg8
  import pin_mux_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);
  logic [7:0] value_q;
  logic [7:0] value_d;

  // undefined bits never store
  assign value_d = wr_en ? (wr_data & MASK) : value_q; // R16

  always_ff @(posedge mclk)
  begin
    if (rst)
      value_q <= RESET_VALUE; // R15
    else
      value_q <= value_d;
  end

  assign value = value_q;
endmodule // ctrl_reg8
`default_nettype wire

// file: logic/wave_pin_gate.sv
/*
 wave_pin_gate: applies timer mode to the six waveform pin selects.
 assumes split mode is a level from the timer unit, synchronous to mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module wave_pin_gate
(
  input wire logic split_mode,
  input wire logic [5:0] wave_bits,
  output logic [5:0] wave_sel
);
  // upper three waveforms exist only in split mode
  assign wave_sel[5:3] = split_mode ? wave_bits[5:3] : 3'h0; // R9 R10
  // lower three act in both modes; in split mode they steer low-byte channels
  assign wave_sel[2:0] = wave_bits[2:0]; // R11 R12
endmodule // wave_pin_gate
`default_nettype wire

// file: logic/pin_location_mux.sv
/*
 pin_location_mux: four control registers on an Avalon-MM slave that steer
 peripheral functions between default and alternative pins and gate event outputs.
 assumes the master holds each request until waitrequest is low; split_mode
 comes from the timer unit on mclk.
*/
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: control A bit 5 moves lookup table 1 output to alternative pin.
// R2: control A bit 4 moves lookup table 0 output to alternative pin.
// R3: control A bit 2 connects event output 2 to its pin.
// R4: control A bit 1 connects event output 1 to its pin.
// R5: control A bit 0 connects event output 0 to its pin.
// R6: control B bit 4 moves all two-wire signals to alternative pins.
// R7: control B bit 2 moves all serial peripheral signals to alternative pins.
// R8: control B bit 0 moves all async serial signals to alternative pins.
// R9: control C bits 5..3 select alternative pins for waveforms 5..3 in split mode.
// R10: in normal timer mode control C bits 5..3 are ignored.
// R11: control C bits 2..0 select alternative pins for waveforms 2..0 always.
// R12: in split mode bits 2..0 steer low-byte compare channels 2..0.
// R13: control D bit 1 moves timer B 1 output to alternative pin.
// R14: control D bit 0 moves timer B 0 output to alternative pin.
// R15: reset clears all four registers to zero.
// R16: undefined bits read zero and ignore writes.
module pin_location_mux
  import pin_mux_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire pin_mux_pkg::bus_req_s bus_req,
  output logic [pin_mux_pkg::DATA_W-1:0] readdata,
  output logic readdatavalid,
  output logic waitrequest,
  input wire logic split_mode,
  input wire logic [2:0] event_in,
  output logic [2:0] event_pin,
  output pin_mux_pkg::pin_select_s pin_sel
);
  import pin_mux_pkg::*;

  logic ack_q;
  logic [DATA_W-1:0] readdata_q;
  logic [DATA_W-1:0] readdata_d;
  wire logic access;
  wire logic [1:0] index;
  wire logic mapped;
  wire logic lane0;
  wire logic [3:0] wr_en;
  wire logic [7:0] reg_val [4];
  wire logic [5:0] wave_sel;

  // one wait cycle per access: taken on the edge where ack_q is high
  assign access = bus_req.read | bus_req.write;
  assign waitrequest = access & ~ack_q;
  assign index = bus_req.address[3:2];
  assign mapped = (bus_req.address[1:0] == 2'h0);
  assign lane0 = bus_req.byteenable[0];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_reg
      localparam logic [7:0] MASK_G = (g == 0) ? MASK_LUT_EVENT :
                                      (g == 1) ? MASK_COMM_PINS :
                                      (g == 2) ? MASK_TIMER_A : MASK_TIMER_B;
      assign wr_en[g] = bus_req.write & ack_q & mapped & lane0 & (index == 2'(g));
      ctrl_reg8 #(.MASK(MASK_G)) u_reg
      (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_en[g]),
        .wr_data(bus_req.writedata[7:0]),
        .value(reg_val[g])
      );
    end
  endgenerate

  // unmapped (misaligned) addresses read zero and drop writes
  assign readdata_d = mapped ? {24'h000000, reg_val[index]} : 32'h00000000; // R16

  always_ff @(posedge mclk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= access & ~ack_q;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      readdata_q <= 32'h00000000;
    else if (bus_req.read & ~ack_q)
      readdata_q <= readdata_d;
  end

  // readdata is registered in the wait cycle so it stands at the taking edge
  assign readdata = readdata_q;
  assign readdatavalid = bus_req.read & ack_q;

  wave_pin_gate u_wave
  (
    .split_mode(split_mode),
    .wave_bits(reg_val[IDX_TIMER_A][5:0]),
    .wave_sel(wave_sel)
  );

  always_comb
  begin
    pin_sel.table_one_alt_pin = reg_val[IDX_LUT_EVENT][POS_TABLE_ONE]; // R1
    pin_sel.table_zero_alt_pin = reg_val[IDX_LUT_EVENT][POS_TABLE_ZERO]; // R2
    pin_sel.event_pin_two_enable = reg_val[IDX_LUT_EVENT][POS_EVENT_TWO]; // R3
    pin_sel.event_pin_one_enable = reg_val[IDX_LUT_EVENT][POS_EVENT_ONE]; // R4
    pin_sel.event_pin_zero_enable = reg_val[IDX_LUT_EVENT][POS_EVENT_ZERO]; // R5
    pin_sel.two_wire_alt_pins = reg_val[IDX_COMM_PINS][POS_TWO_WIRE]; // R6
    pin_sel.serial_periph_alt_pins = reg_val[IDX_COMM_PINS][POS_SERIAL_PERIPH]; // R7
    pin_sel.async_serial_alt_pins = reg_val[IDX_COMM_PINS][POS_ASYNC_SERIAL]; // R8
    pin_sel.timer_a_wave_alt_pin = wave_sel; // R9 R11
    pin_sel.timer_b_one_alt_pin = reg_val[IDX_TIMER_B][POS_TIMER_B_ONE]; // R13
    pin_sel.timer_b_zero_alt_pin = reg_val[IDX_TIMER_B][POS_TIMER_B_ZERO]; // R14
  end

  // disabled event outputs stay low, not floating
  assign event_pin = event_in & {pin_sel.event_pin_two_enable,
                                 pin_sel.event_pin_one_enable,
                                 pin_sel.event_pin_zero_enable}; // R3 R4 R5

  // a write is taken at the second edge of its request
  sequence s_write_lut;
    bus_req.write & ~ack_q & mapped & lane0 & (index == IDX_LUT_EVENT);
  endsequence

  sequence s_write_taken;
    bus_req.write & ack_q;
  endsequence

  sequence s_write_comm;
    bus_req.write & ~ack_q & mapped & lane0 & (index == IDX_COMM_PINS);
  endsequence

  sequence s_write_timer_a;
    bus_req.write & ~ack_q & mapped & lane0 & (index == IDX_TIMER_A);
  endsequence

  sequence s_write_timer_b;
    bus_req.write & ~ack_q & mapped & lane0 & (index == IDX_TIMER_B);
  endsequence

  // a write that hits no register: misaligned, or its byte lane is off
  sequence s_write_dropped;
    bus_req.write & ~ack_q & ~(mapped & lane0);
  endsequence

  sequence s_read_wait;
    bus_req.read & ~ack_q;
  endsequence

  sequence s_read_taken;
    bus_req.read & ack_q;
  endsequence

  AST_WRITE_LUT: assert property (@(posedge mclk) disable iff (rst) // R1
    s_write_lut ##1 s_write_taken |=> reg_val[IDX_LUT_EVENT] == ($past(bus_req.writedata[7:0], 1) & MASK_LUT_EVENT))
    else $error("control A write not stored");

  AST_TABLE_ONE: assert property (@(posedge mclk) disable iff (rst) // R1
    pin_sel.table_one_alt_pin == reg_val[IDX_LUT_EVENT][5])
    else $error("table one select wrong");

  AST_TABLE_ZERO: assert property (@(posedge mclk) disable iff (rst) // R2
    pin_sel.table_zero_alt_pin == reg_val[IDX_LUT_EVENT][4])
    else $error("table zero select wrong");

  AST_EVENT_GATE: assert property (@(posedge mclk) disable iff (rst) // R3
    !reg_val[IDX_LUT_EVENT][2] |-> !event_pin[2])
    else $error("event two leaks while disabled");

  AST_EVENT_ONE: assert property (@(posedge mclk) disable iff (rst) // R4
    event_pin[1] == (event_in[1] & reg_val[IDX_LUT_EVENT][1]))
    else $error("event one gating wrong");

  AST_EVENT_ZERO: assert property (@(posedge mclk) disable iff (rst) // R5
    event_pin[0] == (event_in[0] & reg_val[IDX_LUT_EVENT][0]))
    else $error("event zero gating wrong");

  AST_COMM: assert property (@(posedge mclk) disable iff (rst) // R6
    {pin_sel.two_wire_alt_pins, pin_sel.serial_periph_alt_pins, pin_sel.async_serial_alt_pins}
      == {reg_val[IDX_COMM_PINS][4], reg_val[IDX_COMM_PINS][2], reg_val[IDX_COMM_PINS][0]})
    else $error("comm pin selects wrong");

  AST_NORMAL_IGNORE: assert property (@(posedge mclk) disable iff (rst) // R10
    !split_mode |-> pin_sel.timer_a_wave_alt_pin[5:3] == 3'h0)
    else $error("upper waveforms steered in normal mode");

  AST_SPLIT_HIGH: assert property (@(posedge mclk) disable iff (rst) // R9
    split_mode |-> pin_sel.timer_a_wave_alt_pin == reg_val[IDX_TIMER_A][5:0])
    else $error("split mode waveform selects wrong");

  AST_LOW_WAVE: assert property (@(posedge mclk) disable iff (rst) // R11
    pin_sel.timer_a_wave_alt_pin[2:0] == reg_val[IDX_TIMER_A][2:0])
    else $error("low waveform selects wrong");

  AST_TIMER_B: assert property (@(posedge mclk) disable iff (rst) // R13
    {pin_sel.timer_b_one_alt_pin, pin_sel.timer_b_zero_alt_pin} == reg_val[IDX_TIMER_B][1:0])
    else $error("timer b selects wrong");

  AST_RESET_CLEAR: assert property (@(posedge mclk) // R15
    rst |=> (reg_val[0] == 8'h00) && (reg_val[1] == 8'h00) && (reg_val[2] == 8'h00) && (reg_val[3] == 8'h00))
    else $error("registers not cleared by reset");

  AST_RESERVED: assert property (@(posedge mclk) disable iff (rst) // R16
    ((reg_val[0] & ~MASK_LUT_EVENT) == 8'h00) && ((reg_val[1] & ~MASK_COMM_PINS) == 8'h00)
      && ((reg_val[2] & ~MASK_TIMER_A) == 8'h00)
      && ((reg_val[3] & ~MASK_TIMER_B) == 8'h00))
    else $error("reserved bit stored");

  AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (rst)
    $rose(access) |-> waitrequest ##1 !waitrequest)
    else $error("access not answered after one wait cycle");

  AST_WRITE_COMM: assert property (@(posedge mclk) disable iff (rst) // R6
    s_write_comm ##1 s_write_taken
      |=> reg_val[IDX_COMM_PINS] == ($past(bus_req.writedata[7:0], 1) & MASK_COMM_PINS))
    else $error("control B write not stored");

  AST_WRITE_TIMER_A: assert property (@(posedge mclk) disable iff (rst) // R9
    s_write_timer_a ##1 s_write_taken
      |=> reg_val[IDX_TIMER_A] == ($past(bus_req.writedata[7:0], 1) & MASK_TIMER_A))
    else $error("control C write not stored");

  AST_WRITE_TIMER_B: assert property (@(posedge mclk) disable iff (rst) // R13
    s_write_timer_b ##1 s_write_taken
      |=> reg_val[IDX_TIMER_B] == ($past(bus_req.writedata[7:0], 1) & MASK_TIMER_B))
    else $error("control D write not stored");

  AST_WRITE_DROPPED: assert property (@(posedge mclk) disable iff (rst) // R16
    s_write_dropped ##1 s_write_taken
      |=> (reg_val[0] == $past(reg_val[0], 1)) && (reg_val[1] == $past(reg_val[1], 1))
      && (reg_val[2] == $past(reg_val[2], 1)) && (reg_val[3] == $past(reg_val[3], 1)))
    else $error("dropped write changed a register");

  // a store may only happen at the taking edge, never in the wait cycle
  AST_NO_EARLY_STORE: assert property (@(posedge mclk) disable iff (rst) // R1
    s_write_lut |=> reg_val[IDX_LUT_EVENT] == $past(reg_val[IDX_LUT_EVENT], 1))
    else $error("control A stored before the taking edge");

  // the read word is captured in the wait cycle, so it must stand at the taking edge
  AST_READ_UPPER: assert property (@(posedge mclk) disable iff (rst) // R16
    s_read_wait ##1 s_read_taken |-> readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  AST_READ_ALIGNED: assert property (@(posedge mclk) disable iff (rst)
    bus_req.read & ack_q & mapped |-> readdata == {24'h000000, reg_val[index]})
    else $error("read data does not match register");

  AST_READ_UNMAPPED: assert property (@(posedge mclk) disable iff (rst) // R16
    bus_req.read & ack_q & ~mapped |-> readdata == 32'h00000000)
    else $error("misaligned read not zero");

  AST_READ_VALID: assert property (@(posedge mclk) disable iff (rst)
    s_read_wait ##1 s_read_taken |-> readdatavalid && !waitrequest)
    else $error("read not answered at taking edge");

  AST_VALID_ONLY_READ: assert property (@(posedge mclk) disable iff (rst)
    readdatavalid |-> bus_req.read && !waitrequest)
    else $error("readdatavalid outside a taken read");

  AST_IDLE_READY: assert property (@(posedge mclk) disable iff (rst)
    !access |-> !waitrequest)
    else $error("waitrequest high while idle");

  AST_ACK_PULSE: assert property (@(posedge mclk) disable iff (rst)
    ack_q |=> !ack_q)
    else $error("acknowledge held longer than one cycle");

  AST_SERIAL_PERIPH: assert property (@(posedge mclk) disable iff (rst) // R7
    pin_sel.serial_periph_alt_pins == reg_val[IDX_COMM_PINS][2])
    else $error("serial peripheral select wrong");

  AST_ASYNC_SERIAL: assert property (@(posedge mclk) disable iff (rst) // R8
    pin_sel.async_serial_alt_pins == reg_val[IDX_COMM_PINS][0])
    else $error("async serial select wrong");

  AST_SPLIT_LOW: assert property (@(posedge mclk) disable iff (rst) // R12
    split_mode |-> pin_sel.timer_a_wave_alt_pin[2:0] == reg_val[IDX_TIMER_A][2:0])
    else $error("low-byte channel selects wrong in split mode");

  AST_EVENT_TWO: assert property (@(posedge mclk) disable iff (rst) // R3
    event_pin[2] == (event_in[2] & reg_val[IDX_LUT_EVENT][2]))
    else $error("event two gating wrong");

  AST_TIMER_B_ZERO: assert property (@(posedge mclk) disable iff (rst) // R14
    pin_sel.timer_b_zero_alt_pin == reg_val[IDX_TIMER_B][0])
    else $error("timer b zero select wrong");

  // reset must leave every pin at its default and every event output off
  AST_RESET_OUTPUTS: assert property (@(posedge mclk) // R15
    rst |=> (pin_sel == '0) && (event_pin == 3'h0))
    else $error("pins not at default after reset");

  AST_RESET_READDATA: assert property (@(posedge mclk) // R15
    rst |=> (readdata == 32'h00000000) && !ack_q)
    else $error("bus state not cleared by reset");
endmodule // pin_location_mux
`default_nettype wire

// file: tb/pin_location_mux_tb.sv
/*
 pin_location_mux_tb: self-checking bench for the pin-location multiplexer.
 assumes one 25 MHz clock, a synchronous active-high reset and an Avalon-MM slave
 that may hold waitrequest for up to 50 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_location_mux_tb;
  import pin_mux_pkg::*;
  logic mclk;
  logic rst;
  bus_req_s req;
  logic [DATA_W-1:0] rd;
  logic rdv;
  logic wtr;
  logic split_mode;
  logic [2:0] event_in;
  logic [2:0] event_pin;
  pin_select_s pin_sel;
  int error_cnt;
  int checks;
  int cyc;
  logic [7:0] sh [4];
  logic [7:0] mk [4];
  logic [31:0] q;
  logic [7:0] d;

  pin_location_mux dut (
    .mclk(mclk),
    .rst(rst),
    .bus_req(req),
    .readdata(rd),
    .readdatavalid(rdv),
    .waitrequest(wtr),
    .split_mode(split_mode),
    .event_in(event_in),
    .event_pin(event_pin),
    .pin_sel(pin_sel)
  );

  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic results();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole run needs about 1200 cycles; this only cuts a hang short
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waitrequest is sampled at each rising edge; the edge that sees it low is the taking edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] dat, input logic be0,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{read: ~wr, write: wr, address: a, byteenable: {3'h0, be0}, writedata: {24'h0, dat}};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wtr !== 1'h0 && n < 50);
    r = rd;
    chk({31'h0, wtr}, 32'h0);
    chk({31'h0, rdv}, {31'h0, ~wr});
    req <= '0;
  endtask

  function automatic pin_select_s exp_sel(input logic s);
    exp_sel = '{sh[0][5], sh[0][4], sh[0][2], sh[0][1], sh[0][0], sh[1][4], sh[1][2], sh[1][0],
                {sh[2][5:3] & {3{s}}, sh[2][2:0]}, sh[3][1], sh[3][0]};
  endfunction

  task automatic check_all();
    for (int r = 0; r < 4; r++)
    begin
      bus(1'h0, {r[1:0], 2'h0}, 8'h00, 1'h1, q);
      chk(q, {24'h0, sh[r]});
    end
    chk({16'h0, pin_sel}, {16'h0, exp_sel(split_mode)});
    chk({29'h0, event_pin}, {29'h0, event_in & sh[0][2:0]});
  endtask

  initial
  begin
    rst = 1'h1;
    req = '0;
    split_mode = 1'h0;
    event_in = 3'h7;
    mk = '{MASK_LUT_EVENT, MASK_COMM_PINS, MASK_TIMER_A, MASK_TIMER_B};
    sh = '{default: 8'h00};
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    check_all();
    for (int s = 0; s < 2; s++)
    begin
      split_mode <= s[0];
      event_in <= s[0] ? 3'h5 : 3'h7;
      // step 8 writes zero, so each field is seen alone before the next register
      for (int r = 0; r < 4; r++)
        for (int b = 0; b < 9; b++)
        begin
          d = (b == 8) ? 8'h00 : 8'(1 << b);
          bus(1'h1, {r[1:0], 2'h0}, d, 1'h1, q);
          sh[r] = d & mk[r];
          check_all();
        end
    end
    // misaligned address and a write without its byte lane are both dropped
    bus(1'h1, 4'h1, 8'hFF, 1'h1, q);
    bus(1'h1, 4'h0, 8'hFF, 1'h0, q);
    bus(1'h0, 4'h1, 8'h00, 1'h1, q);
    chk(q, 32'h0);
    check_all();
    for (int r = 0; r < 4; r++)
    begin
      bus(1'h1, {r[1:0], 2'h0}, 8'hFF, 1'h1, q);
      sh[r] = mk[r];
    end
    check_all();
    split_mode <= 1'h0;
    check_all();
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    sh = '{default: 8'h00};
    check_all();
    results();
  end
endmodule // pin_location_mux_tb
`default_nettype wire
